//--- design/rja_link.sv
// Purpose: One link of the receive jitter attenuator: FIFO, read DPLL, slip and jitter
// Assumes: In-strobe marks a recovered-clock bit; output strobe is the de-jittered clock
// Notes: Read rate comes from an NCO steered by a first-order loop on FIFO fill
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module rja_link
  import rja_pkg::*;
#(
  parameter int DEPTH_MAX = 128,
  parameter int NCO_W = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire logic [7:0] cfg,
  input wire logic e1_mode,
  input wire logic peak_clr,
  // Line in
  input wire rja_line_t line_in,
  // Line out
  output logic out_data,
  output logic out_strobe,
  // Status
  output logic slip_evt,
  output logic [6:0] jitter_value
);
  import rja_pkg::*;
  localparam int AW = $clog2(DEPTH_MAX);
  // Half the accumulator range; the reset step is one sixteenth of it
  localparam logic [NCO_W-1:0] NCO_HALF = NCO_W'(1) << (NCO_W - 1);

  // All link state except the FIFO memory in one struct
  typedef struct packed {
    logic [AW:0] fill;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [NCO_W-1:0] acc;
    logic [NCO_W-1:0] step;
    logic [6:0] jit;
    logic run;
    logic [2:0] cfg_seen;
    logic dout;
    logic dstb;
  } rja_link_t;
  rja_link_t st_q, st_d;
  logic mem [DEPTH_MAX];

  // Depth in bits from the code
  function automatic logic [AW:0] depth_of(input logic [1:0] dp);
    case (dp)
      RJA_DP_32: depth_of = (AW+1)'(32);
      RJA_DP_64: depth_of = (AW+1)'(64);
      default: depth_of = (AW+1)'(128);
    endcase
  endfunction

  // Guard distance from full or empty
  function automatic logic [AW:0] guard_of(input logic [1:0] dp);
    case (dp)
      RJA_DP_32: guard_of = RJA_GUARD_32[AW:0];
      RJA_DP_64: guard_of = RJA_GUARD_64[AW:0];
      default: guard_of = RJA_GUARD_128[AW:0];
    endcase
  endfunction

  logic en, limt, peak, bw;
  logic [1:0] dp;
  logic [AW:0] depth, guard;
  logic rd_tick, wr_en;
  logic [NCO_W:0] nsum;
  int shift;
  assign en = cfg[RJA_CFG_EN];
  assign dp = cfg[RJA_CFG_DP +: 2];
  assign bw = cfg[RJA_CFG_BW];
  assign limt = cfg[RJA_CFG_LIMT];
  assign peak = cfg[RJA_CFG_PEAK];
  assign depth = depth_of(dp);
  assign guard = guard_of(dp);
  assign wr_en = line_in.strobe;

  // Loop bandwidth picks the correction shift
  always_comb begin
    if (e1_mode) begin
      shift = bw ? RJA_SHIFT_E1_NARR : RJA_SHIFT_E1_WIDE;
    end else begin
      shift = bw ? RJA_SHIFT_T1_NARR : RJA_SHIFT_T1_WIDE;
    end
  end

  // FIFO store on the recovered-clock strobe; jittered data goes in here
  always_ff @(posedge clk) begin
    if (wr_en && en) begin
      mem[st_q.wp] <= line_in.data;
    end
  end

  // Next state
  always_comb begin
    logic [NCO_W-1:0] corr;
    logic [AW:0] fill_n;
    corr = '0;
    fill_n = '0;
    st_d = st_q;
    st_d.dstb = 1'b0;
    slip_evt = 1'b0;
    nsum = {1'b0, st_q.acc} + {1'b0, st_q.step};
    rd_tick = 1'b0;
    st_d.cfg_seen = {en, dp};
    if (!en) begin
      // Bypass: recovered bit passes straight through
      st_d.dout = line_in.data;
      st_d.dstb = line_in.strobe;
      st_d.wp = '0;
      st_d.rp = '0;
      st_d.fill = '0;
      st_d.run = 1'b0;
    end else if (st_q.cfg_seen != {en, dp}) begin
      // Restart so the read pointer sits half a FIFO behind
      st_d.wp = '0;
      st_d.rp = '0;
      st_d.fill = '0;
      st_d.run = 1'b0;
    end else begin
      if (wr_en) begin
        st_d.wp = AW'((st_q.wp + 1'b1) % depth);
      end
      // Hold reads until the fill reaches half depth
      if (!st_q.run && st_q.fill >= (depth >> 1)) begin
        st_d.run = 1'b1;
      end
      st_d.acc = nsum[NCO_W-1:0];
      rd_tick = st_q.run && nsum[NCO_W];
      // Read-rate limiting near the edges
      if (limt && st_q.run) begin
        if (st_q.fill >= depth - guard) begin
          rd_tick = 1'b1;
        end else if (st_q.fill <= guard) begin
          rd_tick = 1'b0;
        end
      end
      // Underflow: read with nothing stored
      if (rd_tick && st_q.fill == '0 && !wr_en) begin
        slip_evt = 1'b1;
        rd_tick = 1'b0;
        st_d.fill = depth >> 1;
        st_d.rp = AW'((st_q.wp - (depth >> 1)) % depth);
      end else if (wr_en && !rd_tick && st_q.fill == depth) begin
        // Overflow: write into a full FIFO
        slip_evt = 1'b1;
        st_d.fill = depth >> 1;
        st_d.rp = AW'((st_q.wp + 1'b1 - (depth >> 1)) % depth);
      end else begin
        fill_n = st_q.fill + (AW+1)'(wr_en) - (AW+1)'(rd_tick);
        st_d.fill = fill_n;
        if (rd_tick) begin
          st_d.dout = mem[st_q.rp];
          st_d.dstb = 1'b1;
          st_d.rp = AW'((st_q.rp + 1'b1) % depth);
        end
      end
      // DPLL: trim the step toward keeping fill at half depth
      if (wr_en && st_q.run) begin
        corr = NCO_W'(NCO_HALF >> shift);
        if (st_q.fill > (depth >> 1)) begin
          st_d.step = st_q.step + (corr >> 4);
        end else if (st_q.fill < (depth >> 1)) begin
          st_d.step = st_q.step - (corr >> 4);
        end
      end
    end
    // Pointer interval measurement
    if (peak_clr) begin
      st_d.jit = '0;
    end else if (!peak) begin
      st_d.jit = 7'(st_q.fill);
    end else if (7'(st_q.fill) > st_q.jit) begin
      st_d.jit = 7'(st_q.fill);
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.step <= NCO_W'(NCO_HALF >> 4);
    end else begin
      st_q <= st_d;
    end
  end

  assign out_data = st_q.dout;
  assign out_strobe = st_q.dstb;
  assign jitter_value = st_q.jit;
endmodule
`default_nettype wire

//--- design/rja_top.sv
// Purpose: Eight-link receive jitter attenuator with reference clock selection
// Assumes: Line inputs synchronous to CLOCK; register reads answer one cycle later
// Notes: Per-link registers repeat at a 0x100 stride
// Overview of operation
// - Per-link enable inserts or bypasses attenuator
// - Two-bit field picks 32, 64, 128 depth
// - Latency is half the selected depth
// - Write jittered data, read with DPLL clock
// - T1/J1 corner 5 Hz or 1.26 Hz
// - E1 corner 6.77 Hz or 0.87 Hz
// - Overflow or underflow sets slip status
// - Status and enable drive interrupt pin
// - Limit mode trims read rate near edges
// - Guard of 2, 3, 4 bits by depth
// - Mode zero loads live pointer distance
// - Mode one keeps the peak distance
// - Two outputs select any link clock
// - Lost link gives master clock or high
// - Recovered clock keeps phase without pulses
// - Jitter value readable per link, 0x100 stride
`timescale 1ns/1ns
`default_nettype none
module rja_top
  import rja_pkg::*;
#(
  parameter int LINKS = 8,
  parameter int DEPTH_MAX = 128
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Register port
  input wire rja_pkg::rja_bus_t BUS,
  output logic [7:0] RDATA,
  // Line side, one entry per link, plus the master oscillator input
  input wire rja_pkg::rja_line_t [7:0] LINE_IN,
  input wire logic [7:0] RECOVERED_CLOCK,
  input wire logic CRYSTAL_OSCILLATOR_INPUT,
  // Framer side
  output logic [7:0] RX_DATA,
  output logic [7:0] RX_STROBE,
  // Reference clocks and interrupt
  output logic REF_CLOCK_OUT_A,
  output logic REF_CLOCK_OUT_B,
  output logic IRQ
);
  import rja_pkg::*;

  // All top state in one struct
  typedef struct packed {
    logic [7:0][7:0] cfg;
    logic [7:0] mode;
    logic [7:0] ien;
    logic [7:0] ist;
    logic [7:0] ref_ctl;
    logic [7:0] rdata;
    logic [7:0] peak_clr;
  } rja_top_t;
  rja_top_t st_q, st_d;
  logic [7:0] slip;
  logic [7:0][6:0] jit;

  // Link decode from the address
  function automatic logic [2:0] link_of(input logic [11:0] a);
    link_of = a[10:8];
  endfunction

  // Pick a reference clock; loss of signal falls back
  function automatic logic ref_pick(input logic [2:0] sel, input logic fb,
                                    input logic [7:0] rc, input logic [7:0] signal_absence,
                                    input logic mclk);
    if (signal_absence[sel]) begin
      ref_pick = fb ? 1'b1 : mclk;
    end else begin
      ref_pick = rc[sel];
    end
  endfunction

  // Link instances
  for (genvar g = 0; g < 8; g++) begin : g_link
    rja_link #(.DEPTH_MAX(DEPTH_MAX)) u_link (
      .clk(CLOCK),
      .rst(RESET),
      .cfg(st_q.cfg[g]),
      .e1_mode(st_q.mode[g]),
      .peak_clr(st_q.peak_clr[g]),
      .line_in(LINE_IN[g]),
      .out_data(RX_DATA[g]),
      .out_strobe(RX_STROBE[g]),
      .slip_evt(slip[g]),
      .jitter_value(jit[g])
    );
  end

  // Register writes, reads and status
  always_comb begin
    logic [2:0] lk;
    logic [11:0] ofs;
    lk = link_of(BUS.addr);
    ofs = {4'h0, BUS.addr[7:0]};
    st_d = st_q;
    st_d.peak_clr = '0;
    st_d.rdata = '0;
    // Write side
    if (BUS.wr) begin
      case (ofs)
        RJA_OFS_CFG: st_d.cfg[lk] = BUS.wdata;
        RJA_OFS_MODE: st_d.mode[lk] = BUS.wdata[RJA_MODE_E1];
        RJA_OFS_IEN: st_d.ien[lk] = BUS.wdata[RJA_IEN_BIT];
        RJA_OFS_IST: begin
          // Write one to clear
          if (BUS.wdata[RJA_IST_BIT]) begin
            st_d.ist[lk] = 1'b0;
          end
        end
        RJA_OFS_JIT: st_d.peak_clr[lk] = 1'b1;
        RJA_OFS_REF: begin
          if (lk == 3'h0) begin
            st_d.ref_ctl = BUS.wdata;
          end
        end
        default: ;
      endcase
    end
    // Slip events win over a clear in the same cycle
    st_d.ist = st_d.ist | slip;
    // Read side, one cycle later
    if (BUS.rd) begin
      case (ofs)
        RJA_OFS_CFG: st_d.rdata = st_q.cfg[lk];
        RJA_OFS_MODE: st_d.rdata = {7'h00, st_q.mode[lk]};
        RJA_OFS_IEN: st_d.rdata = {7'h00, st_q.ien[lk]};
        RJA_OFS_IST: st_d.rdata = {7'h00, st_q.ist[lk]};
        RJA_OFS_JIT: st_d.rdata = {1'b0, jit[lk]};
        RJA_OFS_REF: st_d.rdata = st_q.ref_ctl;
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      st_q <= '0;
      st_q.ref_ctl <= RJA_REF_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs
  logic [7:0] los_v;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      los_v[i] = LINE_IN[i].signal_absence;
    end
  end
  assign RDATA = st_q.rdata;
  assign IRQ = |(st_q.ist & st_q.ien);
  assign REF_CLOCK_OUT_A = ref_pick(st_q.ref_ctl[RJA_REF_A +: 3], st_q.ref_ctl[RJA_REF_FB],
                                    RECOVERED_CLOCK, los_v, CRYSTAL_OSCILLATOR_INPUT);
  assign REF_CLOCK_OUT_B = ref_pick(st_q.ref_ctl[RJA_REF_B +: 3], st_q.ref_ctl[RJA_REF_FB],
                                    RECOVERED_CLOCK, los_v, CRYSTAL_OSCILLATOR_INPUT);
endmodule
`default_nettype wire

//--- shared/rja_pkg.sv
// Purpose: Shared constants and types for the receive jitter attenuator block
// Assumes: Single 50 MHz clock; line bits arrive as one-cycle strobes
// Notes: Register indices are byte offsets on a plain port
package rja_pkg;
  // Register offsets
  localparam logic [11:0] RJA_OFS_CFG = 12'h0027;
  localparam logic [11:0] RJA_OFS_IEN = 12'h0034;
  localparam logic [11:0] RJA_OFS_JIT = 12'h0039;
  localparam logic [11:0] RJA_OFS_IST = 12'h003B;
  localparam logic [11:0] RJA_OFS_REF = 12'h003E;
  localparam logic [11:0] RJA_OFS_MODE = 12'h0020;
  localparam logic [11:0] RJA_LINK_STRIDE = 12'h0100;
  // Configuration field positions
  localparam int RJA_CFG_EN = 0;
  localparam int RJA_CFG_DP = 1;
  localparam int RJA_CFG_BW = 3;
  localparam int RJA_CFG_LIMT = 4;
  localparam int RJA_CFG_PEAK = 5;
  localparam int RJA_IEN_BIT = 0;
  localparam int RJA_IST_BIT = 0;
  localparam int RJA_REF_FB = 0;
  localparam int RJA_REF_A = 1;
  localparam int RJA_REF_B = 4;
  localparam int RJA_MODE_E1 = 0;
  // Reset values
  localparam logic [7:0] RJA_CFG_RST = 8'h00;
  localparam logic [7:0] RJA_REF_RST = 8'h00;
  // Depth codes
  localparam logic [1:0] RJA_DP_32 = 2'h0;
  localparam logic [1:0] RJA_DP_64 = 2'h1;
  localparam logic [1:0] RJA_DP_128 = 2'h2;
  // Guard band before full or empty, per depth
  localparam logic [7:0] RJA_GUARD_32 = 8'h02;
  localparam logic [7:0] RJA_GUARD_64 = 8'h03;
  localparam logic [7:0] RJA_GUARD_128 = 8'h04;
  // Loop corner frequencies in milli-hertz
  localparam int RJA_CORNER_T1_WIDE_MHZ = 5000;
  localparam int RJA_CORNER_T1_NARR_MHZ = 1260;
  localparam int RJA_CORNER_E1_WIDE_MHZ = 6770;
  localparam int RJA_CORNER_E1_NARR_MHZ = 870;
  // Loop gain shift derived from corner frequency (bigger shift, lower corner)
  localparam int RJA_SHIFT_T1_WIDE = 10;
  localparam int RJA_SHIFT_T1_NARR = 12;
  localparam int RJA_SHIFT_E1_WIDE = 10;
  localparam int RJA_SHIFT_E1_NARR = 13;
  // Register bus request, one port shared by all links
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rja_bus_t;
  // Per-link line input
  typedef struct packed {
    logic data;
    logic strobe;
    logic signal_absence;
  } rja_line_t;
endpackage

//--- verif/rja_line_src.sv
// Purpose: Recovered line source feeding all eight links
// Assumes: Bit period given in system clocks
// Notes: Period wobbles by two clocks to carry jitter
`timescale 1ns/1ns
`default_nettype none
module rja_line_src
  import rja_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Controls from the bench
  input wire logic [7:0] period,
  input wire logic [7:0] run,
  input wire logic [7:0] signal_absence,
  // Line side of the attenuator
  output var rja_pkg::rja_line_t [7:0] line,
  output logic [7:0] rclk
);
  logic [7:0] cnt [8]; // Phase within the bit
  logic [7:0] nb [8]; // Bits sent, also the data pattern
  logic [7:0] wrap; // End of a jittered bit
  always_comb for (int i = 0; i < 8; i++) wrap[i] = cnt[i] >= period + {6'h00, nb[i][0], 1'b0};
  // Clock keeps running while pulses are absent, so phase is kept
  always_ff @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (rst) begin
        cnt[i] <= 8'h00;
        nb[i] <= 8'h00;
        line[i] <= '0;
        rclk[i] <= 1'b0;
      end else begin
        cnt[i] <= wrap[i] ? 8'h00 : cnt[i] + 8'h01;
        rclk[i] <= cnt[i] < (period >> 1);
        line[i].signal_absence <= signal_absence[i];
        line[i].strobe <= wrap[i] && run[i];
        // Idle data flips so a stale bit never looks valid
        line[i].data <= (wrap[i] && run[i]) ? nb[i][0] ^ nb[i][2] ^ nb[i][3] : ~line[i].data;
        if (wrap[i]) nb[i] <= nb[i] + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/rja_props.sv
// Purpose: Port checks for the jitter attenuator top
// Assumes: Writes land at the edge that takes them
// Notes: Mirrors track bus writes only, never status
`timescale 1ns/1ns
`default_nettype none
module rja_props
  import rja_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Register port
  input wire rja_pkg::rja_bus_t BUS,
  input wire logic [7:0] RDATA,
  // Line and framer side
  input wire rja_pkg::rja_line_t [7:0] LINE_IN,
  input wire logic [7:0] RECOVERED_CLOCK,
  input wire logic CRYSTAL_OSCILLATOR_INPUT,
  input wire logic [7:0] RX_DATA,
  input wire logic [7:0] RX_STROBE,
  // Reference clocks and interrupt
  input wire logic REF_CLOCK_OUT_A,
  input wire logic REF_CLOCK_OUT_B,
  input wire logic IRQ
);
  logic [7:0] ref_q, ien_q, cfg_q, fill_q; // Mirrors and link 0 fill
  wire logic w0 = BUS.wr && BUS.addr[10:8] == 3'h0; // Write to link 0
  wire logic wc = w0 && BUS.addr[7:0] == RJA_OFS_CFG[7:0]; // Link 0 config write
  wire logic [2:0] sa = ref_q[3:1];
  wire logic [2:0] sb = ref_q[6:4];
  wire logic [7:0] half = cfg_q[2] ? 8'h40 : (cfg_q[1] ? 8'h20 : 8'h10);
  // Fill restarts only on enable or depth change, the only changes that restart the link
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ref_q <= 8'h00;
      ien_q <= 8'h00;
      cfg_q <= 8'h00;
      fill_q <= 8'h00;
    end else begin
      if (w0 && BUS.addr[7:0] == RJA_OFS_REF[7:0]) ref_q <= BUS.wdata;
      if (BUS.wr && BUS.addr[7:0] == RJA_OFS_IEN[7:0]) ien_q[BUS.addr[10:8]] <= BUS.wdata[0];
      if (wc) cfg_q <= BUS.wdata;
      if (wc && BUS.wdata[2:0] != cfg_q[2:0]) fill_q <= 8'h00;
      else if (LINE_IN[0].strobe && fill_q != 8'hFF) fill_q <= fill_q + 8'h01;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  a_rdata_idle: assert property (
    !$past(BUS.rd) |-> RDATA == 8'h00) else $error("read data outside answer cycle");
  a_jitter_width: assert property (
    $past(BUS.rd) && $past(BUS.addr[7:0]) == RJA_OFS_JIT[7:0] |-> !RDATA[7])
    else $error("jitter value wider than 7 bits");
  a_ref_readback: assert property (
    $past(BUS.rd) && $past(BUS.addr[7:0]) == RJA_OFS_REF[7:0] |-> RDATA == $past(ref_q))
    else $error("ref control read back wrong");
  a_ref_a_live: assert property (
    !LINE_IN[sa].signal_absence |-> REF_CLOCK_OUT_A == RECOVERED_CLOCK[sa]) else $error("ref a wrong link");
  a_ref_a_lost: assert property (
    LINE_IN[sa].signal_absence |-> REF_CLOCK_OUT_A == (ref_q[0] | CRYSTAL_OSCILLATOR_INPUT))
    else $error("ref a wrong fallback");
  a_ref_b_live: assert property (
    !LINE_IN[sb].signal_absence |-> REF_CLOCK_OUT_B == RECOVERED_CLOCK[sb]) else $error("ref b wrong link");
  a_ref_b_lost: assert property (
    LINE_IN[sb].signal_absence |-> REF_CLOCK_OUT_B == (ref_q[0] | CRYSTAL_OSCILLATOR_INPUT))
    else $error("ref b wrong fallback");
  a_irq_masked: assert property (
    ien_q == 8'h00 |-> !IRQ) else $error("interrupt with all enables clear");
  a_bypass_delay: assert property (
    !cfg_q[0] && !$past(cfg_q[0]) |-> RX_STROBE[0] == $past(LINE_IN[0].strobe))
    else $error("bypass strobe not one cycle late");
  a_half_fill: assert property (
    cfg_q[0] && $past(cfg_q[0]) && RX_STROBE[0] |-> fill_q >= half)
    else $error("output before half depth filled");
  c_out: cover property (cfg_q[0] && RX_STROBE[0]);
  c_irq: cover property (IRQ);
  c_lost: cover property (LINE_IN[sa].signal_absence && ref_q[0]);
endmodule
bind rja_top rja_props u_props (.*);
`default_nettype wire

//--- verif/tb_rja_top.sv
// Purpose: Register and stream checks of the attenuator top
// Assumes: Source runs a bit every 25 to 27 clocks
// Notes: Link 0 carries depth tests, link 1 the slip test
`timescale 1ns/1ns
`default_nettype none
module tb_rja_top
  import rja_pkg::*;
();
  logic CLOCK = 1'b0, RESET = 1'b1, osc = 1'b0, ref_a, ref_b, irq;
  rja_bus_t bus = '0;
  logic [7:0] rdata, rx_data, rx_stb, rclk, period = 8'd24, run = 8'hFF, signal_absence = 8'h00;
  rja_line_t [7:0] line;
  int num_errors = 0, compares = 0;
  rja_line_src src (.clk(CLOCK), .rst(RESET), .period(period), .run(run), .signal_absence(signal_absence),
    .line(line), .rclk(rclk));
  rja_top DUT (.CLOCK(CLOCK), .RESET(RESET), .BUS(bus), .RDATA(rdata), .LINE_IN(line),
    .RECOVERED_CLOCK(rclk), .CRYSTAL_OSCILLATOR_INPUT(osc), .RX_DATA(rx_data),
    .RX_STROBE(rx_stb), .REF_CLOCK_OUT_A(ref_a), .REF_CLOCK_OUT_B(ref_b), .IRQ(irq));
  initial forever #10 CLOCK = ~CLOCK;
  // Master clock at half rate
  always @(posedge CLOCK) osc <= ~osc;
  task automatic summarize;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge CLOCK);
    bus.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge CLOCK);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge CLOCK);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e, input string n);
    logic [7:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask
  // Counts input bits until the first output bit; bounded
  // A strobe left over from bypass is ignored on the first edge
  task automatic first_out(input int l, output int n, output logic b);
    logic seen;
    n = 0;
    b = 1'bx;
    seen = 1'b0;
    for (int k = 0; k < 4000 && !seen; k++) begin
      @(posedge CLOCK);
      #1;
      seen = k > 0 && rx_stb[l] === 1'b1;
      if (!seen && line[l].strobe === 1'b1 && n == 0) b = line[l].data;
      n += int'(!seen && line[l].strobe === 1'b1);
    end
    if (!seen) begin
      num_errors++;
      summarize();
    end
  endtask
  initial begin
    logic [7:0] v, p;
    int n, h;
    logic b;
    repeat (10) @(posedge CLOCK);
    RESET <= 1'b0;
    rchk(12'h027, RJA_CFG_RST, "config reset");
    rchk(12'h03E, RJA_REF_RST, "ref control reset");
    rchk(12'h0FF, 8'h00, "unmapped read");
    // Every depth code, bandwidth and line mode once
    for (int d = 0; d < 4; d++) begin
      wr(12'h027, 8'h00);
      wr(12'h020, {7'h00, d[1]});
      wr(12'h027, 8'(1 + 2 * d + 8 * (d % 2)));
      h = 16 << (d > 2 ? 2 : d);
      first_out(0, n, b);
      chk("fill at first output", 8'h01, 8'(n >= h && n <= h + 2));
      chk("first bit", {7'h00, b}, {7'h00, rx_data[0]});
    end
    rd(12'h039, v);
    chk("live distance", 8'h01, 8'(v >= 60 && v <= 68));
    wr(12'h027, 8'h27);
    rd(12'h039, v);
    repeat (300) @(posedge CLOCK);
    rd(12'h039, p);
    chk("peak holds", 8'h01, 8'(p >= v));
    // Starve link 1 so reads outrun writes
    wr(12'h127, 8'h01);
    first_out(1, n, b);
    run[1] <= 1'b0;
    v = 8'h00;
    for (int k = 0; k < 1000 && v[0] !== 1'b1; k++) rd(12'h13B, v);
    chk("slip status", 8'h01, {7'h00, v[0]});
    chk("irq masked", 8'h00, {7'h00, irq});
    wr(12'h134, 8'h01);
    #1 chk("irq raised", 8'h01, {7'h00, irq});
    wr(12'h127, 8'h00);
    run[1] <= 1'b1;
    wr(12'h13B, 8'h01);
    #1 chk("irq cleared", 8'h00, {7'h00, irq});
    wr(12'h134, 8'h00);
    // Starve link 2 with the limit on: reads stop at the guard, no slip
    wr(12'h227, 8'h11);
    first_out(2, n, b);
    run[2] <= 1'b0;
    repeat (1500) @(posedge CLOCK);
    rchk(12'h239, RJA_GUARD_32, "limit floor");
    rchk(12'h23B, 8'h00, "limit avoids slip");
    // Each link on both outputs; both picked links lost on odd passes, fallback high from pass 4
    for (int i = 0; i < 8; i++) begin
      signal_absence <= (8'(i % 2) << i) | (8'(i % 2) << (7 - i));
      v = 8'(2 * i + 16 * (7 - i) + int'(i >= 4));
      wr(12'h03E, v);
      rchk(12'h03E, v, "ref control");
      chk("ref a", {7'h00, i[0] ? 1'(i > 3) | osc : rclk[i]}, {7'h00, ref_a});
      chk("ref b", {7'h00, i[0] ? 1'(i > 3) | osc : rclk[7 - i]}, {7'h00, ref_b});
    end
    summarize();
  end
endmodule
`default_nettype wire
